// [tb/mde_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

module mde_far_model #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  output var logic [CNT_W-1:0] tx_free_cnt,
  output var logic [CNT_W-1:0] tx_level,
  output var logic [CNT_W-1:0] tx_fifo_threshold,
  output var logic [CNT_W-1:0] rx_level,
  output var logic [CNT_W-1:0] rx_fifo_threshold,
  output var mde_pkg::mde_rx_evt_t rx_evt
);
  // Idle far side: both FIFOs empty, thresholds out of reach, no events.
  initial
  begin
    tx_free_cnt = CNT_W'(8'h40);
    tx_level = '0;
    tx_fifo_threshold = CNT_W'(8'h64);
    rx_level = '0;
    rx_fifo_threshold = CNT_W'(8'h64);
    rx_evt = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Levels change right after an edge and stand until the next call.
  task automatic set_tx(input logic [CNT_W-1:0] free, input logic [CNT_W-1:0] lvl,
                        input logic [CNT_W-1:0] thr);
    @(posedge core_clk);
    tx_free_cnt <= free;
    tx_level <= lvl;
    tx_fifo_threshold <= thr;
  endtask

  task automatic set_rx(input logic [CNT_W-1:0] lvl, input logic [CNT_W-1:0] thr);
    @(posedge core_clk);
    rx_level <= lvl;
    rx_fifo_threshold <= thr;
  endtask

  // Event strobes last exactly one cycle, qualifiers travel with them.
  task automatic pulse(input mde_pkg::mde_rx_evt_t v);
    @(posedge core_clk);
    rx_evt <= v;
    @(posedge core_clk);
    rx_evt <= '0;
  endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic core_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0] tx_free, tx_lvl, tx_thr, rx_lvl, rx_thr;
  mde_pkg::mde_rx_evt_t rx_evt;
  logic irq;
  logic [1:0] clk_sel;
  logic dbl;
  logic rsv;
  logic [31:0] rv;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  mde_event_flags #(.CNT_W(8), .RX_DEPTH(64), .STALL_CYCLES(8)) i_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_free_cnt(tx_free),
    .tx_level(tx_lvl), .tx_fifo_threshold(tx_thr), .rx_level(rx_lvl),
    .rx_fifo_threshold(rx_thr), .rx_evt(rx_evt), .irq(irq), .clk_sel(clk_sel),
    .bus_clk_double(dbl), .clk_sel_reserved(rsv));

  mde_far_model #(.CNT_W(8)) i_far (
    .core_clk(core_clk), .tx_free_cnt(tx_free), .tx_level(tx_lvl),
    .tx_fifo_threshold(tx_thr), .rx_level(rx_lvl), .rx_fifo_threshold(rx_thr),
    .rx_evt(rx_evt));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic exp_st(input logic [31:0] e);
    rd(8'h08);
    chk("status", e, rv);
  endtask

  task automatic ev(input logic [8:0] v);
    i_far.pulse(mde_pkg::mde_rx_evt_t'(v));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_clock();
    rd(8'h0C);
    chk("ratio reset", 32'h0, rv);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h0C, {28'hFFFFFFF, c[1:0], 2'h3});
      rd(8'h0C);
      chk("ratio field", {28'h0, c[1:0], 2'h0}, rv);
      chk("clk_sel", {30'h0, c[1:0]}, {30'h0, clk_sel});
      chk_bit("double", c == 1, dbl);
      chk_bit("reserved", c > 1, rsv);
    end
    $display("t_clock done");
  endtask

  task automatic t_events();
    logic [8:0] e [9] = '{9'h100, 9'h180, 9'h040, 9'h060, 9'h018, 9'h010, 9'h006, 9'h004,
                          9'h001};
    logic [31:0] x [9] = '{32'h8000, 32'h8080, 32'h0040, 32'h0, 32'h0200, 32'h0, 32'h0020,
                           32'h0, 32'h0};
    for (int i = 0; i < 9; i++)
    begin
      rd(8'h08);
      ev(e[i]);
      exp_st(32'h0001_0001 | x[i]);
    end
    $display("t_events done");
  endtask

  task automatic t_tx();
    i_far.set_tx(8'h03, 8'h05, 8'h0A);
    rd(8'h08);
    exp_st(32'h0002_0001);
    i_far.set_tx(8'h04, 8'h05, 8'h0A);
    rd(8'h08);
    exp_st(32'h0000_0001);
    i_far.set_tx(8'h0B, 8'h05, 8'h0A);
    exp_st(32'h0004_0001);
    exp_st(32'h0000_0001);
    i_far.set_tx(8'h40, 8'h00, 8'h64);
    rd(8'h08);
    exp_st(32'h0001_0001);
    $display("t_tx done");
  endtask

  // Empty flag of the old level is caught once more at the edge of the change.
  task automatic t_rx();
    i_far.set_rx(8'h00, 8'h02);
    rd(8'h08);
    i_far.set_rx(8'h03, 8'h02);
    exp_st(32'h0001_0005);
    repeat (12) @(posedge core_clk);
    exp_st(32'h0001_0008);
    exp_st(32'h0001_0000);
    i_far.set_rx(8'h40, 8'h02);
    rd(8'h08);
    exp_st(32'h0001_0002);
    ev(9'h004);
    exp_st(32'h0001_0022);
    i_far.set_rx(8'h00, 8'h64);
    rd(8'h08);
    $display("t_rx done");
  endtask

  task automatic t_irq();
    rd(8'h20);
    chk("mask reset", 32'h0, rv);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    chk("mask bits", 32'h0007_82EF, rv);
    chk_bit("irq empty", 1'b1, irq);
    wr(8'h20, 32'h0000_0200);
    rd(8'h08);
    chk_bit("irq idle", 1'b0, irq);
    ev(9'h040);
    #1;
    chk_bit("irq masked", 1'b0, irq);
    ev(9'h018);
    #1;
    chk_bit("irq set", 1'b1, irq);
    wr(8'h08, 32'h0000_0000);
    #1;
    chk_bit("irq kept", 1'b1, irq);
    wr(8'h08, 32'h0000_0200);
    #1;
    chk_bit("irq cleared", 1'b0, irq);
    exp_st(32'h0001_0041);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped", 32'h0, rv);
    wr(8'h20, 32'h0);
    $display("t_irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_clock();
    t_events();
    t_tx();
    t_rx();
    t_irq();
    wrap_up();
  end
endmodule

`default_nettype wire

// [verilog/mde_event_flags.sv]
// Behaviour
// - A rise of free transmit entries above the transmit threshold sets the transmit entry flag.
// - Fewer than four free transmit byte entries set the transmit full flag.
// - An empty transmit FIFO sets the transmit empty flag.
// - Completion of one receive descriptor, after write-back, sets the current-done flag.
// - Completion of the last descriptor of the chain sets the chain-done flag.
// - A bus error response while the arbiter grants the receive FIFO sets the bus error flag.
// - A fetched receive descriptor with a zero valid bit sets the invalid descriptor flag.
// - A frame arriving while the receive FIFO is not empty or a fetch runs sets lost-packet.
// - Receive data stalled longer than the allowed time sets the timeout flag.
// - A rise of valid receive entries above the receive threshold sets the receive entry flag.
// - A full receive FIFO sets the receive full flag.
// - An empty receive FIFO sets the receive empty flag.
// - Reserved status and clock configuration bits always read as zero.
// - Clock ratio code 00 means equal clocks, 01 means bus clock twice, 10 and 11 reserved.
`timescale 1ns/1ps
`default_nettype none

module mde_event_flags #(
  parameter int CNT_W = mde_pkg::CNT_W_DEF,
  parameter int RX_DEPTH = mde_pkg::RX_DEPTH_DEF,
  parameter int STALL_CYCLES = mde_pkg::RX_STALL_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [mde_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [CNT_W-1:0] tx_free_cnt,
  input wire logic [CNT_W-1:0] tx_level,
  input wire logic [CNT_W-1:0] tx_fifo_threshold,
  input wire logic [CNT_W-1:0] rx_level,
  input wire logic [CNT_W-1:0] rx_fifo_threshold,
  input wire mde_pkg::mde_rx_evt_t rx_evt,
  output logic irq,
  output logic [1:0] clk_sel,
  output logic bus_clk_double,
  output logic clk_sel_reserved
);

  ////////////////////////////////////////////////////////////////////////////
  // State and stall timer.
  mde_pkg::mde_state_t s;
  mde_pkg::mde_state_t n;
  logic stall_expired;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic hit_status;
  logic hit_ccr;
  logic hit_mask;
  logic tx_trig;
  logic rx_trig;
  logic rx_not_empty;

  assign rx_not_empty = (rx_level != '0);

  mde_stall_timer #(
    .LIMIT(STALL_CYCLES)
  ) u_stall (
    .core_clk(core_clk),
    .rst(rst),
    .active(rx_not_empty),
    .progress(rx_evt.pop),
    .expired(stall_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    n = s;
    set_v = '0;
    clr_v = '0;
    hit_status = (reg_addr == mde_pkg::OFS_STATUS);
    hit_ccr = (reg_addr == mde_pkg::OFS_CCR);
    hit_mask = (reg_addr == mde_pkg::OFS_MASK);
    tx_trig = (tx_free_cnt > tx_fifo_threshold);
    rx_trig = (rx_level > rx_fifo_threshold);
    n.tx_trig = tx_trig;
    n.rx_trig = rx_trig;

    // Trigger flags mark the moment the DMA is triggered, not the level.
    set_v[mde_pkg::BIT_TX_ENTRY] = tx_trig & ~s.tx_trig;
    set_v[mde_pkg::BIT_TX_FULL] = (tx_free_cnt < CNT_W'(mde_pkg::TX_FULL_MIN_FREE));
    set_v[mde_pkg::BIT_TX_EMPTY] = (tx_level == '0);
    set_v[mde_pkg::BIT_RX_CURR] = rx_evt.desc_done;
    set_v[mde_pkg::BIT_RX_CHAIN] = rx_evt.desc_done & rx_evt.desc_last;
    set_v[mde_pkg::BIT_RX_MERR] = rx_evt.bus_err & rx_evt.grant_rx;
    set_v[mde_pkg::BIT_RX_INVALID] = rx_evt.fetch_done & ~rx_evt.fetch_valid;
    set_v[mde_pkg::BIT_RX_LOST] = rx_evt.frame_start & (rx_not_empty | rx_evt.fetch_busy);
    set_v[mde_pkg::BIT_RECV_STALL_TIMEOUT_FLAG] = stall_expired;
    set_v[mde_pkg::BIT_RX_ENTRY] = rx_trig & ~s.rx_trig;
    set_v[mde_pkg::BIT_RX_FULL] = (rx_level == CNT_W'(RX_DEPTH));
    set_v[mde_pkg::BIT_RX_EMPTY] = ~rx_not_empty;

    // Write one to clear; a read of the status word also clears it.
    if (reg_wr && hit_status)
    begin
      clr_v = reg_wdata;
    end
    if (reg_rd && hit_status)
    begin
      clr_v = '1;
    end
    // A new event in the clearing cycle wins over the clear.
    n.status = ((s.status & ~clr_v) | set_v) & mde_pkg::STATUS_IMPL_MASK;

    if (reg_wr && hit_mask)
    begin
      n.mask = reg_wdata & mde_pkg::STATUS_IMPL_MASK;
    end
    if (reg_wr && hit_ccr)
    begin
      n.sel = reg_wdata[mde_pkg::CCR_SEL_LSB +: mde_pkg::CCR_SEL_W];
    end
    n.ratio_double = (n.sel == mde_pkg::SEL_DOUBLE);
    n.ratio_rsvd = n.sel[1];

    // Read data stand only in the cycle after the read strobe.
    n.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        mde_pkg::OFS_STATUS: n.rdata = s.status;
        mde_pkg::OFS_CCR: n.rdata = 32'(s.sel) << mde_pkg::CCR_SEL_LSB;
        mde_pkg::OFS_MASK: n.rdata = s.mask;
        default: n.rdata = '0;
      endcase
    end
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '{status: mde_pkg::STATUS_RST, mask: mde_pkg::MASK_RST, sel: mde_pkg::SEL_RST,
             rdata: 32'h0000_0000, irq: 1'b0, ratio_double: 1'b0, ratio_rsvd: 1'b0,
             tx_trig: 1'b0, rx_trig: 1'b0};
    end
    else
    begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign irq = s.irq;
  assign clk_sel = s.sel;
  assign bus_clk_double = s.ratio_double;
  assign clk_sel_reserved = s.ratio_rsvd;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Helper: consecutive cycles of stalled receive data, saturating.
  logic [mde_pkg::TMR_W-1:0] stall_run_q;
  always_ff @(posedge core_clk)
  begin
    if (rst || !rx_not_empty || rx_evt.pop)
    begin
      stall_run_q <= '0;
    end
    else if (stall_run_q != {mde_pkg::TMR_W{1'b1}})
    begin
      stall_run_q <= stall_run_q + mde_pkg::TMR_W'(1);
    end
  end

  tx_entry_set_a: assert property ($rose(tx_free_cnt > tx_fifo_threshold)
    |=> s.status[mde_pkg::BIT_TX_ENTRY])
    else $error("tx entry flag not set on trigger");

  tx_full_set_a: assert property ((tx_free_cnt < CNT_W'(4))
    |=> s.status[mde_pkg::BIT_TX_FULL])
    else $error("tx full flag not set");

  tx_empty_set_a: assert property ((tx_level == '0) |=> s.status[mde_pkg::BIT_TX_EMPTY])
    else $error("tx empty flag not set");

  curr_done_a: assert property (rx_evt.desc_done |=> s.status[mde_pkg::BIT_RX_CURR])
    else $error("current done flag not set");

  chain_done_a: assert property ($rose(s.status[mde_pkg::BIT_RX_CHAIN])
    |-> $past(rx_evt.desc_done) && $past(rx_evt.desc_last))
    else $error("chain done set without last descriptor");

  bus_error_a: assert property ($rose(s.status[mde_pkg::BIT_RX_MERR])
    |-> $past(rx_evt.bus_err) && $past(rx_evt.grant_rx))
    else $error("bus error flag set without granted error");

  invalid_desc_a: assert property (rx_evt.fetch_done && !rx_evt.fetch_valid
    |=> s.status[mde_pkg::BIT_RX_INVALID])
    else $error("invalid descriptor flag not set");

  lost_packet_a: assert property ($rose(s.status[mde_pkg::BIT_RX_LOST])
    |-> $past(rx_evt.frame_start) && ($past(rx_not_empty) || $past(rx_evt.fetch_busy)))
    else $error("lost packet flag set without cause");

  stall_timeout_a: assert property (stall_expired
    |-> stall_run_q == mde_pkg::TMR_W'(STALL_CYCLES) ##1 s.status[mde_pkg::BIT_RECV_STALL_TIMEOUT_FLAG])
    else $error("stall timeout at wrong count");

  rx_entry_set_a: assert property ($rose(rx_level > rx_fifo_threshold)
    |=> s.status[mde_pkg::BIT_RX_ENTRY])
    else $error("rx entry flag not set on trigger");

  rx_levels_a: assert property ((rx_level == CNT_W'(RX_DEPTH)) || (rx_level == '0)
    |=> s.status[mde_pkg::BIT_RX_FULL] || s.status[mde_pkg::BIT_RX_EMPTY])
    else $error("rx full or empty flag not set");

  reserved_zero_a: assert property (((s.status & ~mde_pkg::STATUS_IMPL_MASK) == '0)
    && ((s.rdata & ~mde_pkg::STATUS_IMPL_MASK & ~mde_pkg::CCR_IMPL_MASK) == '0))
    else $error("reserved bit read as one");

  ratio_decode_a: assert property (reg_wr && hit_ccr
    |=> clk_sel == $past(reg_wdata[3:2]) ##1 bus_clk_double == (clk_sel == 2'h1)
        && clk_sel_reserved == clk_sel[1])
    else $error("clock ratio decode wrong");

  w1c_keep_a: assert property (reg_wr && hit_status
    |=> ((s.status & $past(s.status) & ~$past(reg_wdata)) == ($past(s.status) & ~$past(reg_wdata))))
    else $error("status bit lost on zero write");

  irq_level_a: assert property (irq == |(s.status & s.mask))
    else $error("interrupt level disagrees with status");

  stall_cover_c: cover property (stall_expired);
  lost_cover_c: cover property (rx_evt.frame_start && rx_evt.fetch_busy);
  clear_race_c: cover property (reg_wr && hit_status && reg_wdata[mde_pkg::BIT_RX_CURR]
    && rx_evt.desc_done);
  irq_cover_c: cover property ($rose(irq));

endmodule

`default_nettype wire

// [verilog/mde_pkg.sv]
package mde_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int RX_STALL_TIME_NS = 20480;
  localparam int RX_STALL_CYCLES = (RX_STALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CCR = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h20;

  localparam int BIT_TX_ENTRY = 18;
  localparam int BIT_TX_FULL = 17;
  localparam int BIT_TX_EMPTY = 16;
  localparam int BIT_RX_CURR = 15;
  localparam int BIT_RX_MERR = 9;
  localparam int BIT_RX_CHAIN = 7;
  localparam int BIT_RX_INVALID = 6;
  localparam int BIT_RX_LOST = 5;
  localparam int BIT_RECV_STALL_TIMEOUT_FLAG = 3;
  localparam int BIT_RX_ENTRY = 2;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_RX_EMPTY = 0;
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h0007_82EF;

  localparam int CCR_SEL_LSB = 2;
  localparam int CCR_SEL_W = 2;
  localparam logic [31:0] CCR_IMPL_MASK = 32'h0000_000C;
  localparam logic [1:0] SEL_EQUAL = 2'h0;
  localparam logic [1:0] SEL_DOUBLE = 2'h1;

  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [1:0] SEL_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // FIFO geometry.
  localparam int CNT_W_DEF = 8;
  localparam int RX_DEPTH_DEF = 64;
  localparam int TX_FULL_MIN_FREE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers and state.
  typedef struct packed {
    logic desc_done;
    logic desc_last;
    logic fetch_done;
    logic fetch_valid;
    logic bus_err;
    logic grant_rx;
    logic frame_start;
    logic fetch_busy;
    logic pop;
  } mde_rx_evt_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [1:0] sel;
    logic [31:0] rdata;
    logic irq;
    logic ratio_double;
    logic ratio_rsvd;
    logic tx_trig;
    logic rx_trig;
  } mde_state_t;

  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic expired;
  } mde_tmr_t;

endpackage

// [verilog/mde_stall_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module mde_stall_timer #(
  parameter int LIMIT = mde_pkg::RX_STALL_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic active,
  input wire logic progress,
  output logic expired
);

  mde_pkg::mde_tmr_t q;
  mde_pkg::mde_tmr_t d;

  // The count saturates at the limit so one stall gives one pulse.
  always_comb
  begin
    d = q;
    d.expired = 1'b0;
    if (!active || progress)
    begin
      d.count = '0;
    end
    else if (q.count != mde_pkg::TMR_W'(LIMIT))
    begin
      d.count = q.count + mde_pkg::TMR_W'(1);
      d.expired = (d.count == mde_pkg::TMR_W'(LIMIT));
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign expired = q.expired;

endmodule

`default_nettype wire
